// File: smc_lane_if.sv
// interface: lane mapping request and shared pin values
`default_nettype none
interface smc_lane_if;
    import smc_pkg::*;
    smc_width_type width;
    smc_bat_type   byte_access_type;
    smc_size_type  size;
    logic [1:0]    addr_lo;
    logic          active;
    logic          wr_pulse;
    logic          pin_a0_bs0;
    logic          pin_we_wr0;
    logic          pin_bw1_bs1;
    logic          pin_a1_bw2_bs2;
    logic          pin_bw3_bs3;

    modport ctrl (output width, byte_access_type, size, addr_lo, active, wr_pulse,
                  input pin_a0_bs0, pin_we_wr0, pin_bw1_bs1, pin_a1_bw2_bs2, pin_bw3_bs3);
    modport map (input width, byte_access_type, size, addr_lo, active, wr_pulse,
                 output pin_a0_bs0, pin_we_wr0, pin_bw1_bs1, pin_a1_bw2_bs2, pin_bw3_bs3);
endinterface : smc_lane_if
`default_nettype wire

// File: smc_lane_map.sv
// module: byte lane mask and shared control pin multiplexing
`default_nettype none
module smc_lane_map
    import smc_pkg::*;
(
    smc_lane_if.map lane
);
    logic [LANES-1:0] mask;
    logic [LANES-1:0] bs_n;
    logic [LANES-1:0] wr_n;

    // lanes touched by the access, from size and low address bits
    always_comb begin
        mask = 4'h1;
        if (lane.width == WIDTH_16) begin
            if (lane.size == SIZE_BYTE) begin
                mask = lane.addr_lo[0] ? 4'h2 : 4'h1;                 // RULE20
            end else begin
                mask = 4'h3;
            end
        end else if (lane.width == WIDTH_32) begin
            if (lane.size == SIZE_BYTE) begin
                mask = 4'(4'h1 << lane.addr_lo);                       // RULE20
            end else if (lane.size == SIZE_HALF) begin
                mask = lane.addr_lo[1] ? 4'hC : 4'h3;
            end else begin
                mask = 4'hF;
            end
        end
    end

    // selects follow the address; writes strobe only in the pulse
    assign bs_n = lane.active ? ~mask : LANES_OFF;                     // RULE18
    assign wr_n = lane.wr_pulse ? ~mask : LANES_OFF;                   // RULE19

    // shared pins: only one strobe family is live per chip select
    always_comb begin
        if (lane.width == WIDTH_8) begin
            lane.pin_a0_bs0     = lane.addr_lo[0];                     // RULE11
            lane.pin_we_wr0     = ~lane.wr_pulse;                      // RULE13
            lane.pin_bw1_bs1    = 1'b1;                                // RULE13
            lane.pin_a1_bw2_bs2 = lane.addr_lo[1];                     // RULE12
            lane.pin_bw3_bs3    = 1'b1;                                // RULE13
        end else if (lane.byte_access_type == BAT_SELECT) begin
            lane.pin_a0_bs0     = bs_n[0];                             // RULE8
            lane.pin_we_wr0     = ~lane.wr_pulse;                      // RULE8
            lane.pin_bw1_bs1    = bs_n[1];
            lane.pin_a1_bw2_bs2 = (lane.width == WIDTH_32) ? bs_n[2] : lane.addr_lo[1];
            lane.pin_bw3_bs3    = (lane.width == WIDTH_32) ? bs_n[3] : 1'b1;   // RULE10
        end else begin
            lane.pin_a0_bs0     = 1'b1;                                // RULE11
            lane.pin_we_wr0     = wr_n[0];                             // RULE7
            lane.pin_bw1_bs1    = wr_n[1];                             // RULE7
            lane.pin_a1_bw2_bs2 = (lane.width == WIDTH_32) ? wr_n[2] : lane.addr_lo[1];
            lane.pin_bw3_bs3    = (lane.width == WIDTH_32) ? wr_n[3] : 1'b1;   // RULE10
        end
    end
endmodule : smc_lane_map
`default_nettype wire

// File: smc_mem_model.sv
// partner: small static memory on the 32-bit lanes with a wait generator
`default_nettype none
module smc_mem_model
    import smc_pkg::*;
(
    // strobes, lanes and address from the controller
    input  wire logic              i_clk,
    input  wire logic              i_rd_n,
    input  wire logic              i_we_n,
    input  wire logic [LANES-1:0]  i_sel_n,
    input  wire logic [3:0]        i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    // wait length and answers
    input  wire logic [2:0]        i_stall,
    output logic      [DATA_W-1:0] o_rdata,
    output logic                   o_wait_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] mem_q [16];
    logic [DATA_W-1:0] last_q = 32'h0;
    logic [2:0]        cnt_q = 3'h0;
    wire logic         stb = !i_rd_n || !i_we_n;
    // selected lanes stored each write cycle; strobe cycles counted for wait
    always @(posedge i_clk) begin
        for (int k = 0; k < LANES; k++)
            if (!i_we_n && !i_sel_n[k]) mem_q[i_addr][8*k+:8] <= i_wdata[8*k+:8];
        cnt_q <= stb ? cnt_q + 3'h1 : 3'h0;
        if (!i_rd_n) last_q <= mem_q[i_addr];
    end
    // released bus shows the inverted last word, so a late sample cannot pass
    assign o_rdata = !i_rd_n ? mem_q[i_addr] : ~last_q;
    // wait held low for the first i_stall strobe cycles
    assign o_wait_n = !(stb && cnt_q < i_stall);
endmodule : smc_mem_model
`default_nettype wire

// File: smc_phase_timer.sv
// module: down counter that times one access phase
`default_nettype none
module smc_phase_timer #(
    parameter int W = 6
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // load and status
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_value,
    output logic              o_done
);
    logic [W-1:0] cnt_q;

    // reload wins; otherwise count down and rest at zero
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= '0;
        end else if (i_load) begin
            cnt_q <= i_value;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - W'(1);
        end
    end

    assign o_done = (cnt_q == '0);
endmodule : smc_phase_timer
`default_nettype wire

// File: smc_pkg.sv
// package: constants and types of the static memory lane controller
`default_nettype none
package smc_pkg;
    localparam int NUM_CS     = 8;
    localparam int CS_W       = 3;
    localparam int ADDR_W     = 26;
    localparam int DATA_W     = 32;
    localparam int LANES      = 4;
    localparam int TIME_W     = 6;
    localparam int PAGE_LSB   = 5;                  // 32-byte page
    localparam logic [CS_W-1:0]   BOOT_CS   = 3'h0;
    localparam logic [TIME_W-1:0] SLOW_SETUP = 6'h01;
    localparam logic [TIME_W-1:0] SLOW_PULSE = 6'h02;
    localparam logic [TIME_W-1:0] SLOW_HOLD  = 6'h01;
    localparam logic [TIME_W-1:0] TIME_ONE   = 6'h01;
    localparam logic [TIME_W-1:0] TIME_ZERO  = 6'h00;
    localparam logic [LANES-1:0]  LANES_OFF  = 4'hF;
    localparam logic [NUM_CS-1:0] CS_OFF     = 8'hFF;
    localparam logic [NUM_CS-1:0] CS_ONE     = 8'h01;

    typedef enum logic [1:0] {
        WIDTH_8  = 2'h0,
        WIDTH_16 = 2'h1,
        WIDTH_32 = 2'h2
    } smc_width_type;

    typedef enum logic {
        BAT_SELECT = 1'h0,
        BAT_WRITE  = 1'h1
    } smc_bat_type;

    typedef enum logic [1:0] {
        SIZE_BYTE = 2'h0,
        SIZE_HALF = 2'h1,
        SIZE_WORD = 2'h2
    } smc_size_type;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_SETUP = 4'h2,
        ST_PULSE = 4'h4,
        ST_HOLD  = 4'h8
    } smc_state_type;

    // boot chip select must come up in a mode it can boot from
    localparam smc_width_type RST_WIDTH = WIDTH_16;
    localparam smc_bat_type   RST_BAT   = BAT_SELECT;
endpackage : smc_pkg
`default_nettype wire

// File: smc_props.sv
// checker: pin relations of the static memory lane controller
`default_nettype none
module smc_props
    import smc_pkg::*;
(
    // clock and reset
    input wire logic              I_CLOCK,
    input wire logic              I_RST,
    // watched pins and status
    input wire logic              o_RSP_VALID,
    input wire logic [1:0]        o_CUR_WIDTH,
    input wire logic              o_CUR_BYTE_ACCESS_TYPE,
    input wire logic [NUM_CS-1:0] o_CHIP_SEL_N,
    input wire logic              o_READ_STROBE_N,
    input wire logic              o_WE_BYTE_WRITE0_N,
    input wire logic              o_A0_BYTE_SEL0_N,
    input wire logic              o_BYTE_WRITE1_SEL1_N,
    input wire logic              o_BYTE_WRITE3_SEL3_N,
    input wire logic              o_DATA_OE_N,
    input wire logic              i_WAIT_REQ_N
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);
    wire logic act = o_CHIP_SEL_N != CS_OFF;
    wire logic bw  = o_CUR_BYTE_ACCESS_TYPE == BAT_WRITE;
    property p_cs; $onehot0(~o_CHIP_SEL_N); endproperty
    a_cs: assert property (p_cs) else $error("two chip selects low");
    property p_done; o_RSP_VALID |-> o_CHIP_SEL_N == CS_OFF && o_READ_STROBE_N; endproperty
    a_done: assert property (p_done) else $error("pins active at finish");
    property p_w8; act && o_CUR_WIDTH == WIDTH_8 |-> o_BYTE_WRITE1_SEL1_N && o_BYTE_WRITE3_SEL3_N;
    endproperty
    a_w8: assert property (p_w8) else $error("lane pins on 8-bit bus");
    property p_a0; act && bw && o_CUR_WIDTH != WIDTH_8 |-> o_A0_BYTE_SEL0_N; endproperty
    a_a0: assert property (p_a0) else $error("select 0 in byte-write");
    property p_rw; !o_READ_STROBE_N |-> o_WE_BYTE_WRITE0_N && o_DATA_OE_N; endproperty
    a_rw: assert property (p_rw) else $error("read and write together");
    property p_wait; !o_READ_STROBE_N && !i_WAIT_REQ_N |=> !o_READ_STROBE_N; endproperty
    a_wait: assert property (p_wait) else $error("wait not honoured");
    property p_boot; !o_CHIP_SEL_N[0] |-> !bw; endproperty
    a_boot: assert property (p_boot) else $error("boot select in byte-write");
    property p_oe; !o_WE_BYTE_WRITE0_N |-> !o_DATA_OE_N; endproperty
    a_oe: assert property (p_oe) else $error("write strobe without data");
    // main scenarios reached
    c_wait: cover property (!o_READ_STROBE_N && !i_WAIT_REQ_N);
    c_bw: cover property (!o_WE_BYTE_WRITE0_N && bw);
    c_w8: cover property (!o_WE_BYTE_WRITE0_N && o_CUR_WIDTH == WIDTH_8);
endmodule : smc_props
`default_nettype wire

// File: smc_static_mem_ctrl.sv
// module: static memory controller pin side with lane mapping
// How it works
// RULE1: eight active-low chip selects, 26-bit address bus, one window each.
// RULE2: 64 Mbyte window per select through address lines 25..0.
// RULE3: full address always driven; small memories wrap in the window.
// RULE4: per-select data width of 8, 16 or 32 bits.
// RULE5: low address bits go unused as the width grows.
// RULE6: 16/32-bit selects pick byte-write or byte-select access.
// RULE7: byte-write: one write strobe per lane, one read strobe.
// RULE8: byte-select: one select per lane, one read and one write enable.
// RULE9: boot select never takes byte-write access.
// RULE10: one strobe family live per chip select.
// RULE11: pin 0 is A0 on 8-bit, select 0 in select mode, else idle.
// RULE12: A1 pin is A1 on 8/16-bit, strobe 2 or select 2 on 32-bit.
// RULE13: 8-bit: shared pin acts as write enable, lane 1/3 pins idle.
// RULE14: a low wait request stretches the access in progress.
// RULE15: slow clock mode uses fixed slow strobe timing.
// RULE16: page mode reads skip setup for hits within a 32-byte page.
// RULE17: all selects and strobes active low; wait active low.
// RULE18: byte selects change together with the address.
// RULE19: byte write strobes share timing with the write enable.
// RULE20: only lanes the access covers are strobed.
`default_nettype none
module smc_static_mem_ctrl
    import smc_pkg::*;
(
    // clock and reset
    input  wire logic                I_CLOCK,
    input  wire logic                I_RST,
    // access request from the system side
    input  wire logic                i_REQ_VALID,
    output logic                     o_REQ_READY,
    input  wire logic                i_REQ_WRITE,
    input  wire logic [CS_W-1:0]     i_REQ_CS,
    input  wire logic [ADDR_W-1:0]   i_REQ_ADDR,
    input  wire logic [1:0]          i_REQ_SIZE,
    input  wire logic [DATA_W-1:0]   i_REQ_WDATA,
    // access completion
    output logic                     o_RSP_VALID,
    output logic [DATA_W-1:0]        o_RSP_RDATA,
    // per chip select mode setting load
    input  wire logic                i_MODE_WR,
    input  wire logic [CS_W-1:0]     i_MODE_CS,
    input  wire logic [1:0]          i_MODE_BUS_WIDTH_SEL,
    input  wire logic                i_MODE_BYTE_ACCESS_TYPE,
    input  wire logic                i_MODE_PAGE_EN,
    // strobe timing, in clock cycles
    input  wire logic [TIME_W-1:0]   i_RD_SETUP,
    input  wire logic [TIME_W-1:0]   i_RD_PULSE,
    input  wire logic [TIME_W-1:0]   i_RD_HOLD,
    input  wire logic [TIME_W-1:0]   i_WR_SETUP,
    input  wire logic [TIME_W-1:0]   i_WR_PULSE,
    input  wire logic [TIME_W-1:0]   i_WR_HOLD,
    input  wire logic [TIME_W-1:0]   i_PAGE_PULSE,
    input  wire logic                i_SLOW_CLOCK,
    // status
    output logic                     o_BUSY,
    output logic [1:0]               o_CUR_WIDTH,
    output logic                     o_CUR_BYTE_ACCESS_TYPE,
    // external memory pins
    output logic [NUM_CS-1:0]        o_CHIP_SEL_N,
    output logic                     o_READ_STROBE_N,
    output logic                     o_WE_BYTE_WRITE0_N,
    output logic                     o_A0_BYTE_SEL0_N,
    output logic                     o_BYTE_WRITE1_SEL1_N,
    output logic                     o_A1_BYTE_WRITE2_SEL2_N,
    output logic                     o_BYTE_WRITE3_SEL3_N,
    output logic [ADDR_W-1:2]        o_ADDR,
    input  wire logic [DATA_W-1:0]   i_DATA,
    output logic [DATA_W-1:0]        o_DATA,
    output logic                     o_DATA_OE_N,
    input  wire logic                i_WAIT_REQ_N
);

    smc_width_type  width_q [NUM_CS];
    smc_bat_type    bat_q [NUM_CS];
    logic           page_en_q [NUM_CS];

    smc_state_type  state_q;
    smc_state_type  state_d;

    logic                  wr_q;
    logic [CS_W-1:0]       cs_q;
    logic [ADDR_W-1:0]     addr_q;
    smc_size_type          size_q;
    logic                  hit_q;

    logic                  page_valid_q;
    logic [CS_W-1:0]       page_cs_q;
    logic [ADDR_W-1:PAGE_LSB] page_tag_q;

    logic                  accept;
    logic                  sel_wr;
    logic [CS_W-1:0]       sel_cs;
    logic [ADDR_W-1:0]     sel_addr;
    smc_size_type          sel_size;
    logic                  sel_hit;
    logic                  page_hit;

    logic [TIME_W-1:0]     setup_val;
    logic [TIME_W-1:0]     pulse_val;
    logic [TIME_W-1:0]     hold_val;

    logic                  tmr_load;
    logic [TIME_W-1:0]     tmr_value;
    logic                  tmr_done;
    logic                  pulse_end;

    smc_lane_if lane ();

    // mode settings; the boot select can never take byte-write access
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            for (int i = 0; i < NUM_CS; i++) begin
                width_q[i]   <= RST_WIDTH;
                bat_q[i]     <= RST_BAT;
                page_en_q[i] <= 1'b0;
            end
        end else if (i_MODE_WR) begin
            width_q[i_MODE_CS]   <= smc_width_type'(i_MODE_BUS_WIDTH_SEL); // RULE4
            page_en_q[i_MODE_CS] <= i_MODE_PAGE_EN; // RULE16
            if (i_MODE_CS == BOOT_CS) begin
                bat_q[i_MODE_CS] <= BAT_SELECT; // RULE9
            end else begin
                bat_q[i_MODE_CS] <= smc_bat_type'(i_MODE_BYTE_ACCESS_TYPE); // RULE6
            end
        end
    end

    // a new access is taken only between accesses
    assign o_REQ_READY = (state_q == ST_IDLE);
    assign accept      = i_REQ_VALID && o_REQ_READY;
    assign o_BUSY      = (state_q != ST_IDLE);

    // page hit: same chip select, same 32-byte page, read after a page read
    assign page_hit = !i_REQ_WRITE && !i_SLOW_CLOCK && page_en_q[i_REQ_CS]
                      && page_valid_q && (page_cs_q == i_REQ_CS)
                      && (page_tag_q == i_REQ_ADDR[ADDR_W-1:PAGE_LSB]);      // RULE16

    // the access being started or the one in flight
    always_comb begin
        if (state_q == ST_IDLE) begin
            sel_wr   = i_REQ_WRITE;
            sel_cs   = i_REQ_CS;
            sel_addr = i_REQ_ADDR;
            sel_size = smc_size_type'(i_REQ_SIZE);
            sel_hit  = page_hit;
        end else begin
            sel_wr   = wr_q;
            sel_cs   = cs_q;
            sel_addr = addr_q;
            sel_size = size_q;
            sel_hit  = hit_q;
        end
    end

    // request capture, full address kept for the whole access
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            wr_q    <= 1'b0;
            cs_q    <= '0;
            addr_q  <= '0;
            size_q  <= SIZE_BYTE;
            hit_q   <= 1'b0;
        end else if (accept) begin
            wr_q    <= i_REQ_WRITE;
            cs_q    <= i_REQ_CS;
            addr_q  <= i_REQ_ADDR; // RULE3
            size_q  <= smc_size_type'(i_REQ_SIZE);
            hit_q   <= page_hit;
        end
    end

    // page tracking: any write or non-page access drops the open page
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            page_valid_q <= 1'b0;
            page_cs_q    <= '0;
            page_tag_q   <= '0;
        end else if (accept) begin
            page_valid_q <= !i_REQ_WRITE && page_en_q[i_REQ_CS] && !i_SLOW_CLOCK;
            page_cs_q    <= i_REQ_CS;
            page_tag_q   <= i_REQ_ADDR[ADDR_W-1:PAGE_LSB];
        end
    end

    // phase lengths; slow clock mode overrides what software set
    always_comb begin
        if (i_SLOW_CLOCK) begin
            setup_val = SLOW_SETUP; // RULE15
            pulse_val = SLOW_PULSE; // RULE15
            hold_val  = SLOW_HOLD; // RULE15
        end else if (sel_wr) begin
            setup_val = i_WR_SETUP;
            pulse_val = i_WR_PULSE;
            hold_val  = i_WR_HOLD;
        end else if (sel_hit) begin
            setup_val = TIME_ZERO; // RULE16
            pulse_val = i_PAGE_PULSE;
            hold_val  = i_RD_HOLD;
        end else begin
            setup_val = i_RD_SETUP;
            pulse_val = i_RD_PULSE;
            hold_val  = i_RD_HOLD;
        end
        // a null pulse would be undefined, so it is run as one cycle
        if (pulse_val == TIME_ZERO) begin
            pulse_val = TIME_ONE;
        end
    end

    smc_phase_timer #(
        .W (TIME_W)
    ) u_timer (
        .i_clk   (I_CLOCK),
        .i_rst   (I_RST),
        .i_load  (tmr_load),
        .i_value (tmr_value),
        .o_done  (tmr_done)
    );

    // the pulse only ends once its count is spent and no wait is held
    assign pulse_end = tmr_done && i_WAIT_REQ_N; // RULE14

    // access sequencer: setup, pulse, hold
    always_comb begin
        state_d   = state_q;
        tmr_load  = 1'b0;
        tmr_value = TIME_ZERO;
        case (state_q)
            ST_IDLE: begin
                if (accept) begin
                    tmr_load = 1'b1;
                    if (setup_val != TIME_ZERO) begin
                        state_d   = ST_SETUP;
                        tmr_value = setup_val - TIME_ONE;
                    end else begin
                        state_d   = ST_PULSE;
                        tmr_value = pulse_val - TIME_ONE;
                    end
                end
            end
            ST_SETUP: begin
                if (tmr_done) begin
                    state_d   = ST_PULSE;
                    tmr_load  = 1'b1;
                    tmr_value = pulse_val - TIME_ONE;
                end
            end
            ST_PULSE: begin
                if (pulse_end) begin // RULE14
                    if (hold_val != TIME_ZERO) begin
                        state_d   = ST_HOLD;
                        tmr_load  = 1'b1;
                        tmr_value = hold_val - TIME_ONE;
                    end else begin
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_HOLD: begin
                if (tmr_done) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // lane mapping is driven from the next state so pins line up with it
    assign lane.width    = width_q[sel_cs];
    assign lane.byte_access_type      = bat_q[sel_cs];
    assign lane.size     = sel_size;
    assign lane.addr_lo  = sel_addr[1:0];
    assign lane.active   = (state_d != ST_IDLE);
    assign lane.wr_pulse = (state_d == ST_PULSE) && sel_wr; // RULE19

    smc_lane_map u_lane_map (
        .lane (lane)
    );

    // chip select and address pins, registered and active low
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            o_CHIP_SEL_N <= CS_OFF;
            o_ADDR       <= '0;
        end else begin
            if (state_d != ST_IDLE) begin
                o_CHIP_SEL_N <= ~(NUM_CS'(CS_ONE << sel_cs)); // RULE1
            end else begin
                o_CHIP_SEL_N <= CS_OFF; // RULE17
            end
            if (accept) begin
                o_ADDR <= i_REQ_ADDR[ADDR_W-1:2]; // RULE2
            end
        end
    end

    // strobe pins; the shared low address pins load every edge, while o_ADDR loads only on accept
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            o_READ_STROBE_N         <= 1'b1;
            o_WE_BYTE_WRITE0_N      <= 1'b1;
            o_A0_BYTE_SEL0_N        <= 1'b1;
            o_BYTE_WRITE1_SEL1_N    <= 1'b1;
            o_A1_BYTE_WRITE2_SEL2_N <= 1'b1;
            o_BYTE_WRITE3_SEL3_N    <= 1'b1;
        end else begin
            o_READ_STROBE_N         <= !((state_d == ST_PULSE) && !sel_wr);  // RULE17
            o_WE_BYTE_WRITE0_N      <= lane.pin_we_wr0;                      // RULE13
            o_A0_BYTE_SEL0_N        <= lane.pin_a0_bs0;                      // RULE5
            o_BYTE_WRITE1_SEL1_N    <= lane.pin_bw1_bs1;
            o_A1_BYTE_WRITE2_SEL2_N <= lane.pin_a1_bw2_bs2;                  // RULE5
            o_BYTE_WRITE3_SEL3_N    <= lane.pin_bw3_bs3;                     // RULE10
        end
    end

    // write data is driven for the whole write access
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            o_DATA      <= '0;
            o_DATA_OE_N <= 1'b1;
        end else begin
            if (accept && i_REQ_WRITE) begin
                o_DATA <= i_REQ_WDATA;
            end
            o_DATA_OE_N <= !((state_d != ST_IDLE) && sel_wr);
        end
    end

    // read data is caught on the edge that raises the read strobe
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            o_RSP_RDATA <= '0;
        end else if ((state_q == ST_PULSE) && pulse_end && !wr_q) begin
            o_RSP_RDATA <= i_DATA;
        end
    end

    // completion pulse in the first idle cycle, set on the edge the access leaves its last phase
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            o_RSP_VALID <= 1'b0;
        end else begin
            o_RSP_VALID <= (state_q != ST_IDLE) && (state_d == ST_IDLE);
        end
    end

    // status mirrors the mode of the chip select in use
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            o_CUR_WIDTH            <= RST_WIDTH;
            o_CUR_BYTE_ACCESS_TYPE <= RST_BAT;
        end else begin
            o_CUR_WIDTH            <= width_q[sel_cs];
            o_CUR_BYTE_ACCESS_TYPE <= bat_q[sel_cs];
        end
    end

endmodule : smc_static_mem_ctrl
`default_nettype wire

// File: tb_top.sv
// testbench: lane mapping, cycle time, wait, slow clock and boot select
`default_nettype none
module tb_top import smc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic I_CLOCK, I_RST, i_REQ_VALID, o_REQ_READY, i_REQ_WRITE, o_RSP_VALID, i_MODE_WR;
    logic i_MODE_BYTE_ACCESS_TYPE, i_MODE_PAGE_EN, i_SLOW_CLOCK, o_BUSY, o_CUR_BYTE_ACCESS_TYPE;
    logic o_READ_STROBE_N, o_WE_BYTE_WRITE0_N, o_A0_BYTE_SEL0_N, o_BYTE_WRITE1_SEL1_N;
    logic o_A1_BYTE_WRITE2_SEL2_N, o_BYTE_WRITE3_SEL3_N, o_DATA_OE_N, i_WAIT_REQ_N;
    logic [CS_W-1:0] i_REQ_CS, i_MODE_CS;
    logic [1:0] i_REQ_SIZE, i_MODE_BUS_WIDTH_SEL, o_CUR_WIDTH;
    logic [ADDR_W-1:0] i_REQ_ADDR;
    logic [ADDR_W-1:2] o_ADDR;
    logic [DATA_W-1:0] i_REQ_WDATA, o_RSP_RDATA, i_DATA, o_DATA;
    logic [NUM_CS-1:0] o_CHIP_SEL_N;
    logic [TIME_W-1:0] tm, i_RD_SETUP, i_RD_PULSE, i_RD_HOLD, i_WR_SETUP, i_WR_PULSE;
    logic [TIME_W-1:0] i_WR_HOLD, i_PAGE_PULSE;
    logic [2:0] stall;
    int err_total = 0;
    int cmp_count = 0;
    int lat;
    // {width, type, write, size, addr[1:0], expected shared pins a0 we w1 a1 w3}
    localparam logic [12:0] TBL [9] = '{13'h1607, 13'h0277, 13'h0205, 13'h0A31, 13'h0E7B,
                                        13'h1300, 13'h16DC, 13'h1255, 13'h1508};
    // one knob sets every phase so the cycle time is easy to predict
    assign {i_RD_SETUP, i_WR_SETUP, i_RD_HOLD, i_WR_HOLD} = {4{tm}};
    assign {i_RD_PULSE, i_WR_PULSE, i_PAGE_PULSE} = {3{tm + 6'h01}};
    smc_static_mem_ctrl u_dut (.*);
    smc_mem_model u_mem (.i_clk(I_CLOCK), .i_rd_n(o_READ_STROBE_N), .i_we_n(o_WE_BYTE_WRITE0_N),
        .i_sel_n({o_BYTE_WRITE3_SEL3_N, o_A1_BYTE_WRITE2_SEL2_N, o_BYTE_WRITE1_SEL1_N,
                  o_A0_BYTE_SEL0_N}), .i_addr(o_ADDR[5:2]), .i_wdata(o_DATA),
        .i_stall(stall), .o_rdata(i_DATA), .o_wait_n(i_WAIT_REQ_N));
    initial begin
        I_CLOCK = 1'b0;
        forever #2 I_CLOCK = ~I_CLOCK;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic summarize;
        if (err_total == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize
    // one access: load mode, check pins mid-access, time the answer
    task automatic acc(input logic [2:0] cs, input logic [12:0] e, input logic [23:0] a,
                       input logic [DATA_W-1:0] d);
        {i_MODE_CS, i_MODE_BUS_WIDTH_SEL, i_MODE_BYTE_ACCESS_TYPE, i_MODE_WR} = {cs, e[12:10], 1'b1};
        @(negedge I_CLOCK);
        {i_MODE_WR, i_REQ_WRITE, i_REQ_SIZE, i_REQ_CS} = {1'b0, e[9:7], cs};
        {i_REQ_ADDR, i_REQ_WDATA, i_REQ_VALID} = {a, e[6:5], d, 1'b1};
        @(negedge I_CLOCK);
        i_REQ_VALID = 1'b0;
        @(negedge I_CLOCK);
        chk("lane pins", {27'h0, o_A0_BYTE_SEL0_N, o_WE_BYTE_WRITE0_N, o_BYTE_WRITE1_SEL1_N,
            o_A1_BYTE_WRITE2_SEL2_N, o_BYTE_WRITE3_SEL3_N}, {27'h0, e[4:0]});
        chk("cs busy", {22'h0, o_BUSY, o_REQ_READY, o_CHIP_SEL_N}, {22'h0, 2'h2, ~(CS_ONE << cs)});
        chk("address", {8'h0, o_ADDR}, {8'h0, a});
        lat = 2;
        while (o_RSP_VALID !== 1'b1 && lat < 60) begin
            @(negedge I_CLOCK);
            lat++;
        end
        if (lat >= 60) begin
            err_total++;
            summarize();
        end
    endtask : acc
    initial begin
        {I_RST, tm, stall, i_REQ_VALID, i_MODE_WR, i_MODE_PAGE_EN, i_SLOW_CLOCK} = 14'h2080;
        {i_REQ_WRITE, i_REQ_CS, i_MODE_CS, i_REQ_SIZE} = 9'h0;
        {i_MODE_BUS_WIDTH_SEL, i_MODE_BYTE_ACCESS_TYPE, i_REQ_ADDR, i_REQ_WDATA} = 61'h0;
        repeat (3) @(negedge I_CLOCK);
        I_RST = 1'b0;
        chk("idle selects", {24'h0, o_CHIP_SEL_N}, {24'h0, CS_OFF});
        chk("reset mode", {29'h0, o_CUR_WIDTH, o_CUR_BYTE_ACCESS_TYPE}, 32'h2);
        // every width and access type, boot select forced out of byte-write
        for (int i = 0; i < 9; i++) begin
            acc(3'(i), TBL[i], 24'hF0A5C3 + 24'(i), 32'h5A0F_3C00 + i);
            chk("cycle time", lat, 5);
        end
        acc(3'h2, 13'h1300, 24'h000004, 32'hC3A5_7E18);
        stall = 3'h3;
        acc(3'h2, 13'h1108, 24'h000004, 32'h0);
        chk("read data", o_RSP_RDATA, 32'hC3A5_7E18);
        chk("stretched", lat, 7);
        {stall, tm, i_SLOW_CLOCK} = {3'h0, 6'h03, 1'b1};
        acc(3'h2, 13'h1108, 24'h000004, 32'h0);
        chk("slow cycle", lat, 5);
        {i_SLOW_CLOCK, i_MODE_PAGE_EN} = 2'h1;
        acc(3'h2, 13'h1108, 24'h000004, 32'h0);
        chk("programmed cycle", lat, 11);
        acc(3'h2, 13'h1108, 24'h000004, 32'h0);
        chk("page cycle", lat, 8);
        summarize();
    end
endmodule : tb_top
bind smc_static_mem_ctrl smc_props u_props (.*);
`default_nettype wire
